// file: rtl/cafp_pkg.sv
package cafp_pkg;

   // Register bus request, one cycle per strobe
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } cafp_bus_req_t;

   // Register byte addresses
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_AMODE = 8'h01;
   localparam logic [7:0] OFS_PWMCFG = 8'h02;
   localparam logic [7:0] OFS_CNT_LO = 8'h03;
   localparam logic [7:0] OFS_CNT_HI = 8'h04;
   localparam logic [7:0] OFS_MOD_BASE = 8'h10;
   localparam logic [1:0] OFS_MOD_MODE = 2'h0;
   localparam logic [1:0] OFS_MOD_CPL = 2'h1;
   localparam logic [1:0] OFS_MOD_CPH = 2'h2;

   // Module mode register fields
   localparam int MB_WIDE = 7;
   localparam int MB_ECOM = 6;
   localparam int MB_MAT = 3;
   localparam int MB_TOG = 2;
   localparam int MB_PWM = 1;
   localparam int MB_ECCF = 0;

   // Array control, array mode and pwm config fields
   localparam int CTRL_COF = 7;
   localparam int CTRL_RUN = 6;
   localparam int AMODE_CPS_LSB = 1;
   localparam int AMODE_ECF = 0;
   localparam int PCFG_RELOAD_ACCESS_SELECT = 7;
   localparam int PCFG_ECOV = 6;
   localparam int PCFG_CYCLE_OVERFLOW_FLAG = 5;

   // Values after reset
   localparam logic [7:0] RST_MODE = 8'h00;
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic [2:0] RST_CPS = 3'h0;
   localparam logic [7:0] RST_RDATA = 8'h00;

   // Counter clock divide ratios in system clocks
   localparam logic [3:0] DIV_CPS0 = 4'hc;
   localparam logic [3:0] DIV_CPS1 = 4'h4;
   localparam logic [3:0] DIV_FAST = 4'h1;

   typedef enum logic [1:0] {
      CLEN_8 = 2'b00,
      CLEN_9 = 2'b01,
      CLEN_10 = 2'b10,
      CLEN_11 = 2'b11
   } cafp_clen_t;

   typedef enum logic [1:0] {
      MODE_OTHER = 2'b00,
      MODE_FREQ = 2'b01,
      MODE_PWM_N = 2'b10,
      MODE_PWM16 = 2'b11
   } cafp_mode_t;

   typedef struct packed {
      logic [7:0] mode;
      logic [15:0] cmp;
      logic [15:0] arl;
      logic pin;
      logic flag;
   } cafp_mod_t;

endpackage

// file: rtl/cafp_tick_div.sv
`timescale 1ns/1ns
module cafp_tick_div (
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // Divide ratio, one or more
   input wire logic [3:0] ratio,
   // One-cycle counter clock enable
   output logic tick
);
   import cafp_pkg::*;

   typedef struct packed {
      logic [3:0] cnt;
      logic tick;
   } cafp_div_t;

   cafp_div_t s_r;
   cafp_div_t s_nxt;

   always_comb begin
      s_nxt = s_r;
      // Ratio change lands cleanly: counter restarts when it is passed
      if (s_r.cnt + 4'h1 >= ratio) begin
         s_nxt.cnt = 4'h0;
         s_nxt.tick = 1'b1;
      end else begin
         s_nxt.cnt = s_r.cnt + 4'h1;
         s_nxt.tick = 1'b0;
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign tick = s_r.tick;
endmodule

// file: rtl/cafp_top.sv
// Operation
// - Frequency mode: low match toggles, adds offset
// - Zero offset means 256 counts between toggles
// - Frequency mode needs enable, toggle, pwm bits
// - Frequency match flag on full 16-bit equality
// - One shared cycle length for 8-11 bit
// - 8-bit pwm: high on match, low on wrap
// - 8-bit wrap reloads low compare from high
// - 8-bit pwm: enable, pwm, length 00
// - Pwm match sets match flag when enabled
// - 8-bit cycle overflow flag every 256 counts
// - 9/10/11-bit overflow flag every 512/1024/2048
// - Low byte write clears, high sets enable
// - Pwm with comparator disabled outputs zero
// - Reload register shares compare addresses via select
// - N-bit pwm: high on match, low on overflow
// - N-bit overflow sets flag, loads reload value
// - N-bit pwm selected by nonzero length, right-justified
// - 16-bit pwm by enable, pwm, wide bits
// - 16-bit pwm: match high, overflow low, flag
// - Length codes 00,01,10,11 mean 8..11 bits
// - Enabled match flag raises array interrupt
//
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/1ns
module cafp_top #(
   parameter int NUM_MODULES = 6
) (
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // Register port
   input cafp_pkg::cafp_bus_req_t bus_req,
   output logic [7:0] bus_rdata,
   // Module outputs
   output logic [NUM_MODULES-1:0] module_output_pin,
   output logic irq
);
   import cafp_pkg::*;

   typedef struct packed {
      logic [15:0] cnt;
      logic run;
      logic counter_overflow_flag;
      logic counter_ovf_int_en;
      logic [2:0] counter_clock_select;
      logic reload_access_select;
      logic cycle_ovf_int_en;
      logic cycle_overflow_flag;
      logic [1:0] cycle_length_select;
      cafp_mod_t [NUM_MODULES-1:0] mods;
      logic [7:0] rdata;
      logic irq;
   } cafp_state_t;

   cafp_state_t s_r;
   cafp_state_t s_nxt;
   logic tick;
   logic [3:0] div_ratio;

   function automatic cafp_mode_t mode_of(input logic [7:0] m);
      if (m[MB_PWM] && m[MB_TOG]) begin
         mode_of = MODE_FREQ;
      end else if (m[MB_PWM] && m[MB_WIDE]) begin
         mode_of = MODE_PWM16;
      end else if (m[MB_PWM]) begin
         mode_of = MODE_PWM_N;
      end else begin
         mode_of = MODE_OTHER;
      end
   endfunction

   // Mask of the low N counter bits for the shared length
   function automatic logic [15:0] len_mask(input logic [1:0] len);
      case (cafp_clen_t'(len))
         CLEN_8: len_mask = 16'h00ff;
         CLEN_9: len_mask = 16'h01ff;
         CLEN_10: len_mask = 16'h03ff;
         CLEN_11: len_mask = 16'h07ff;
         default: len_mask = 16'h00ff;
      endcase
   endfunction

   function automatic logic [3:0] cps_ratio(input logic [2:0] cps);
      case (cps)
         3'h0: cps_ratio = DIV_CPS0;
         3'h1: cps_ratio = DIV_CPS1;
         default: cps_ratio = DIV_FAST;
      endcase
   endfunction

   // Module index of an address, NUM_MODULES when unmapped
   function automatic int mod_index(input logic [7:0] a);
      logic [7:0] rel;
      rel = a - OFS_MOD_BASE;
      if (a < OFS_MOD_BASE || int'(rel[7:2]) >= NUM_MODULES ||
          rel[1:0] == 2'h3) begin
         mod_index = NUM_MODULES;
      end else begin
         mod_index = int'(rel[7:2]);
      end
   endfunction

   assign div_ratio = cps_ratio(s_r.counter_clock_select);

   cafp_tick_div u_div (
      .clock(clock),
      .reset(reset),
      .ratio(div_ratio),
      .tick(tick)
   );

   logic [15:0] cnt_inc;
   logic [15:0] nmask;
   logic ovf16;
   logic ovfn;
   logic set_cof;
   logic set_cycle_overflow_flag;
   logic [NUM_MODULES-1:0] set_flag;
   logic [15:0] new_cmp;
   logic hit;
   logic ecom;
   int sel;
   logic [7:0] rd_val;
   logic [7:0] ctrl_val;

   always_comb begin
      s_nxt = s_r;
      cnt_inc = s_r.cnt + 16'h0001;
      // One length for every 8-11 bit module
      nmask = len_mask(s_r.cycle_length_select);
      ovf16 = s_r.cnt == 16'hffff;
      ovfn = (s_r.cnt & nmask) == nmask;
      set_cof = 1'b0;
      set_cycle_overflow_flag = 1'b0;
      set_flag = '0;
      new_cmp = 16'h0000;
      hit = 1'b0;
      ecom = 1'b0;
      sel = mod_index(bus_req.addr);
      rd_val = 8'h00;
      ctrl_val = 8'h00;

      // Counter side events, once per counter increment
      if (tick && s_r.run) begin
         s_nxt.cnt = cnt_inc;
         set_cycle_overflow_flag = ovfn;
         set_cof = ovf16;
         for (int i = 0; i < NUM_MODULES; i++) begin
            ecom = s_r.mods[i].mode[MB_ECOM];
            case (mode_of(s_r.mods[i].mode))
               MODE_FREQ: begin
                  if (cnt_inc[7:0] == s_r.mods[i].cmp[7:0] && ecom) begin
                     s_nxt.mods[i].pin = ~s_r.mods[i].pin;
                     // 8-bit wrap makes a zero offset count 256
                     s_nxt.mods[i].cmp[7:0] =
                        s_r.mods[i].cmp[7:0] + s_r.mods[i].cmp[15:8];
                  end
                  if (cnt_inc == s_r.mods[i].cmp && ecom &&
                      s_r.mods[i].mode[MB_MAT]) begin
                     set_flag[i] = 1'b1;
                  end
               end
               MODE_PWM_N: begin
                  new_cmp = s_r.mods[i].cmp;
                  if (ovfn) begin
                     if (s_r.cycle_length_select == CLEN_8) begin
                        // High byte kept as the next duty
                        new_cmp = {s_r.mods[i].cmp[15:8],
                                   s_r.mods[i].cmp[15:8]};
                     end else begin
                        new_cmp = s_r.mods[i].arl;
                     end
                     s_nxt.mods[i].cmp = new_cmp;
                  end
                  hit = (cnt_inc & nmask) == (new_cmp & nmask);
                  // Match after a wrap wins, so duty zero gives 100%
                  if (hit && ecom) begin
                     s_nxt.mods[i].pin = 1'b1;
                  end else if (ovfn) begin
                     s_nxt.mods[i].pin = 1'b0;
                  end
                  if (hit && ecom && s_r.mods[i].mode[MB_MAT]) begin
                     set_flag[i] = 1'b1;
                  end
               end
               MODE_PWM16: begin
                  hit = cnt_inc == s_r.mods[i].cmp;
                  if (hit && ecom) begin
                     s_nxt.mods[i].pin = 1'b1;
                  end else if (ovf16) begin
                     s_nxt.mods[i].pin = 1'b0;
                  end
                  if (hit && ecom && s_r.mods[i].mode[MB_MAT]) begin
                     set_flag[i] = 1'b1;
                  end
               end
               default: begin
                  // Timer and toggle-on-match, pin held when disabled
                  if (cnt_inc == s_r.mods[i].cmp && ecom) begin
                     if (s_r.mods[i].mode[MB_MAT]) begin
                        set_flag[i] = 1'b1;
                     end
                     if (s_r.mods[i].mode[MB_TOG]) begin
                        s_nxt.mods[i].pin = ~s_r.mods[i].pin;
                     end
                  end
               end
            endcase
         end
      end

      // Register writes; data written wins over hardware updates, except the flag sets below
      if (bus_req.wr) begin
         case (bus_req.addr)
            OFS_CTRL: begin
               s_nxt.counter_overflow_flag = bus_req.wdata[CTRL_COF];
               s_nxt.run = bus_req.wdata[CTRL_RUN];
               for (int i = 0; i < NUM_MODULES; i++) begin
                  s_nxt.mods[i].flag = bus_req.wdata[i];
               end
            end
            OFS_AMODE: begin
               s_nxt.counter_clock_select =
                  bus_req.wdata[AMODE_CPS_LSB+:3];
               s_nxt.counter_ovf_int_en = bus_req.wdata[AMODE_ECF];
            end
            OFS_PWMCFG: begin
               s_nxt.reload_access_select = bus_req.wdata[PCFG_RELOAD_ACCESS_SELECT];
               s_nxt.cycle_ovf_int_en = bus_req.wdata[PCFG_ECOV];
               s_nxt.cycle_overflow_flag = bus_req.wdata[PCFG_CYCLE_OVERFLOW_FLAG];
               s_nxt.cycle_length_select = bus_req.wdata[1:0];
            end
            OFS_CNT_LO: s_nxt.cnt[7:0] = bus_req.wdata;
            OFS_CNT_HI: s_nxt.cnt[15:8] = bus_req.wdata;
            default: begin
               if (sel < NUM_MODULES) begin
                  case (bus_req.addr[1:0] - OFS_MOD_BASE[1:0])
                     OFS_MOD_MODE: s_nxt.mods[sel].mode = bus_req.wdata;
                     OFS_MOD_CPL: begin
                        if (s_r.reload_access_select) begin
                           s_nxt.mods[sel].arl[7:0] = bus_req.wdata;
                        end else begin
                           s_nxt.mods[sel].cmp[7:0] = bus_req.wdata;
                        end
                        s_nxt.mods[sel].mode[MB_ECOM] = 1'b0;
                     end
                     OFS_MOD_CPH: begin
                        if (s_r.reload_access_select) begin
                           s_nxt.mods[sel].arl[15:8] = bus_req.wdata;
                        end else begin
                           s_nxt.mods[sel].cmp[15:8] = bus_req.wdata;
                        end
                        s_nxt.mods[sel].mode[MB_ECOM] = 1'b1;
                     end
                     default: ;
                  endcase
               end
            end
         endcase
      end

      // Hardware set beats a same-cycle software clear
      s_nxt.counter_overflow_flag = s_nxt.counter_overflow_flag | set_cof;
      s_nxt.cycle_overflow_flag = s_nxt.cycle_overflow_flag | set_cycle_overflow_flag;
      for (int i = 0; i < NUM_MODULES; i++) begin
         s_nxt.mods[i].flag = s_nxt.mods[i].flag | set_flag[i];
         // Disabled comparator holds any pwm output at zero
         if (mode_of(s_nxt.mods[i].mode) inside {MODE_PWM_N, MODE_PWM16}
             && !s_nxt.mods[i].mode[MB_ECOM]) begin
            s_nxt.mods[i].pin = 1'b0;
         end
      end

      // Read data stands in the cycle after the strobe only
      for (int i = 0; i < NUM_MODULES; i++) begin
         ctrl_val[i] = s_r.mods[i].flag;
      end
      ctrl_val[CTRL_COF] = s_r.counter_overflow_flag;
      ctrl_val[CTRL_RUN] = s_r.run;
      case (bus_req.addr)
         OFS_CTRL: rd_val = ctrl_val;
         OFS_AMODE: begin
            rd_val[AMODE_CPS_LSB+:3] = s_r.counter_clock_select;
            rd_val[AMODE_ECF] = s_r.counter_ovf_int_en;
         end
         OFS_PWMCFG: begin
            rd_val[PCFG_RELOAD_ACCESS_SELECT] = s_r.reload_access_select;
            rd_val[PCFG_ECOV] = s_r.cycle_ovf_int_en;
            rd_val[PCFG_CYCLE_OVERFLOW_FLAG] = s_r.cycle_overflow_flag;
            rd_val[1:0] = s_r.cycle_length_select;
         end
         OFS_CNT_LO: rd_val = s_r.cnt[7:0];
         OFS_CNT_HI: rd_val = s_r.cnt[15:8];
         default: begin
            if (sel < NUM_MODULES) begin
               case (bus_req.addr[1:0] - OFS_MOD_BASE[1:0])
                  OFS_MOD_MODE: rd_val = s_r.mods[sel].mode;
                  OFS_MOD_CPL: rd_val = s_r.reload_access_select ?
                     s_r.mods[sel].arl[7:0] : s_r.mods[sel].cmp[7:0];
                  OFS_MOD_CPH: rd_val = s_r.reload_access_select ?
                     s_r.mods[sel].arl[15:8] : s_r.mods[sel].cmp[15:8];
                  default: rd_val = 8'h00;
               endcase
            end
         end
      endcase
      s_nxt.rdata = bus_req.rd ? rd_val : 8'h00;

      // Interrupt request from enabled flags
      s_nxt.irq = (s_nxt.counter_overflow_flag & s_nxt.counter_ovf_int_en) |
                  (s_nxt.cycle_overflow_flag & s_nxt.cycle_ovf_int_en);
      for (int i = 0; i < NUM_MODULES; i++) begin
         if (s_nxt.mods[i].flag && s_nxt.mods[i].mode[MB_ECCF]) begin
            s_nxt.irq = 1'b1;
         end
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         s_r.cnt <= RST_WORD;
         s_r.run <= 1'b0;
         s_r.counter_overflow_flag <= 1'b0;
         s_r.counter_ovf_int_en <= 1'b0;
         s_r.counter_clock_select <= RST_CPS;
         s_r.reload_access_select <= 1'b0;
         s_r.cycle_ovf_int_en <= 1'b0;
         s_r.cycle_overflow_flag <= 1'b0;
         s_r.cycle_length_select <= CLEN_8;
         for (int i = 0; i < NUM_MODULES; i++) begin
            s_r.mods[i].mode <= RST_MODE;
            s_r.mods[i].cmp <= RST_WORD;
            s_r.mods[i].arl <= RST_WORD;
            s_r.mods[i].pin <= 1'b0;
            s_r.mods[i].flag <= 1'b0;
         end
         s_r.rdata <= RST_RDATA;
         s_r.irq <= 1'b0;
      end else begin
         s_r <= s_nxt;
      end
   end

   always_comb begin
      for (int i = 0; i < NUM_MODULES; i++) begin
         module_output_pin[i] = s_r.mods[i].pin;
      end
   end

   assign bus_rdata = s_r.rdata;
   assign irq = s_r.irq;
endmodule

// file: test/cafp_chk.sv
`timescale 1ns/1ns
module cafp_chk #(
   parameter int NUM_MODULES = 6
) (
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // Register port and outputs
   input cafp_pkg::cafp_bus_req_t bus_req,
   input logic [7:0] bus_rdata,
   input logic [NUM_MODULES-1:0] module_output_pin,
   input logic irq
);
   import cafp_pkg::*;
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   logic [7:0] mode_r;
   logic [7:0] cph_r;
   logic [15:0] arl_r;
   logic [1:0] clen_r;
   logic reload_access_select_r;
   logic fast_r;
   logic en_r;
   logic pin_r;
   logic quiet_r;
   logic [16:0] gap_r;
   logic [16:0] hi_r;
   logic [7:0] a;
   logic [7:0] w;
   logic fell;
   logic rose;
   logic pwm_n;
   logic freq;
   logic [16:0] len;
   logic [16:0] off;
   logic [16:0] duty;
   assign a = bus_req.addr;
   assign w = bus_req.wdata;
   assign fell = pin_r & ~module_output_pin[0];
   assign rose = ~pin_r & module_output_pin[0];
   assign pwm_n = mode_r[MB_ECOM] & mode_r[MB_PWM] & ~mode_r[MB_TOG];
   assign freq = mode_r[MB_ECOM] & mode_r[MB_PWM] & mode_r[MB_TOG];
   assign len = 17'h100 << clen_r;
   assign off = (cph_r == 8'h00) ? 17'h100 : {9'h0, cph_r};
   assign duty = (clen_r == 2'b00) ? 17'h100 - {9'h0, cph_r} :
      len - ({1'b0, arl_r} & (len - 17'h1));

   // Timing is only judged over a whole cycle with no register write
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         mode_r <= 8'h00;
         cph_r <= 8'h00;
         arl_r <= 16'h0000;
         clen_r <= 2'b00;
         reload_access_select_r <= 1'b0;
         fast_r <= 1'b0;
         en_r <= 1'b0;
         pin_r <= 1'b0;
         quiet_r <= 1'b0;
         gap_r <= 17'h0;
         hi_r <= 17'h0;
      end else begin
         pin_r <= module_output_pin[0];
         gap_r <= fell ? 17'h1 : gap_r + 17'h1;
         hi_r <= rose ? 17'h1 : hi_r + 17'h1;
         quiet_r <= ~bus_req.wr & (quiet_r | fell);
         en_r <= en_r | (bus_req.wr && ((w[0] && (a == 8'h01 ||
            (a >= 8'h10 && a[1:0] == 2'b00))) || (w[6] && a == 8'h02)));
         if (bus_req.wr) begin
            case (a)
               8'h01: fast_r <= w[3:1] >= 3'h2;
               8'h02: begin
                  reload_access_select_r <= w[7];
                  clen_r <= w[1:0];
               end
               8'h10: mode_r <= w;
               // Either mapping of the byte moves the enable
               8'h11: begin
                  if (reload_access_select_r) arl_r[7:0] <= w;
                  mode_r[MB_ECOM] <= 1'b0;
               end
               8'h12: begin
                  if (reload_access_select_r) arl_r[15:8] <= w;
                  else cph_r <= w;
                  mode_r[MB_ECOM] <= 1'b1;
               end
               default: ;
            endcase
         end
      end
   end

   a_period_len: assert property (
      fell && quiet_r && fast_r && pwm_n && !mode_r[MB_WIDE] |->
      gap_r == len) else $error("pwm cycle length wrong");
   a_duty_high: assert property (
      fell && quiet_r && fast_r && pwm_n && !mode_r[MB_WIDE] |->
      hi_r == duty) else $error("pwm high time wrong");
   a_freq_timing: assert property (
      fell && quiet_r && fast_r && freq |-> hi_r == off && gap_r == 2 * off)
      else $error("square wave timing wrong");
   a_pin_zero: assert property (
      mode_r[MB_PWM] && !mode_r[MB_ECOM] && !mode_r[MB_TOG] &&
      $past(mode_r[MB_PWM] && !mode_r[MB_ECOM]) |-> !module_output_pin[0])
      else $error("disabled pwm output high");
   a_low_clears: assert property (
      bus_req.wr && a == 8'h11 && !reload_access_select_r ##1 bus_req.rd && a == 8'h10 |=>
      !bus_rdata[MB_ECOM]) else $error("low write kept enable");
   a_high_sets: assert property (
      bus_req.wr && a == 8'h12 && !reload_access_select_r ##1 bus_req.rd && a == 8'h10 |=>
      bus_rdata[MB_ECOM]) else $error("high write left enable clear");
   a_match_irq: assert property (
      $rose(module_output_pin[0]) && mode_r[MB_PWM] && mode_r[MB_MAT] &&
      mode_r[MB_ECCF] |-> ##[0:1] irq) else $error("match gave no irq");
   a_irq_needs_en: assert property (
      !en_r |-> !irq) else $error("irq without enable");
   a_rdata_idle: assert property (
      !$past(bus_req.rd) |-> bus_rdata == 8'h00)
      else $error("read data outside its cycle");

   c_pwm11: cover property (fell && quiet_r && pwm_n && clen_r == 2'b11);
   c_freq256: cover property (fell && quiet_r && freq && cph_r == 8'h00);
   c_irq: cover property ($rose(irq));
endmodule

bind cafp_top cafp_chk #(.NUM_MODULES(NUM_MODULES)) u_chk (
   .clock(clock),
   .reset(reset),
   .bus_req(bus_req),
   .bus_rdata(bus_rdata),
   .module_output_pin(module_output_pin),
   .irq(irq)
);

// file: test/cafp_load.sv
`timescale 1ns/1ns
module cafp_load (
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // Driven pin
   input wire logic pin,
   // Last high time and fall-to-fall period, in clocks
   output logic [16:0] high_time,
   output logic [16:0] period,
   output logic [7:0] falls
);
   logic pin_r;
   logic [16:0] since_rise;
   logic [16:0] since_fall;

   // Passive load: it never drives back, it only times the pin
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         pin_r <= 1'b0;
         since_rise <= 17'h0;
         since_fall <= 17'h0;
         high_time <= 17'h0;
         period <= 17'h0;
         falls <= 8'h0;
      end else begin
         pin_r <= pin;
         since_rise <= (pin & ~pin_r) ? 17'h1 : since_rise + 17'h1;
         since_fall <= (~pin & pin_r) ? 17'h1 : since_fall + 17'h1;
         if (~pin & pin_r) begin
            high_time <= since_rise;
            period <= since_fall;
            falls <= falls + 8'h1;
         end
      end
   end
endmodule

// file: test/counter_array_freq_pwm_modes_test.sv
`timescale 1ns/1ns
module counter_array_freq_pwm_modes_test;
   import cafp_pkg::*;
   localparam logic [7:0] RST_ADDRS [9] = '{8'h00, 8'h01, 8'h02, 8'h03,
      8'h04, 8'h10, 8'h11, 8'h12, 8'h0f};
   logic clock;
   logic reset;
   cafp_bus_req_t bus_req;
   logic [7:0] bus_rdata;
   logic [5:0] module_output_pin;
   logic irq;
   logic [16:0] high_time [2];
   logic [16:0] period [2];
   logic [7:0] falls [2];
   logic [31:0] seed;
   logic [7:0] d;
   logic [7:0] o;
   logic [16:0] v;
   logic [16:0] e;
   int hits;
   int errors;
   int checks_done;

   cafp_top u_dut (.clock(clock), .reset(reset), .bus_req(bus_req),
      .bus_rdata(bus_rdata), .module_output_pin(module_output_pin),
      .irq(irq));
   for (genvar g = 0; g < 2; g++) begin : g_load
      cafp_load u_load (.clock(clock), .reset(reset),
         .pin(module_output_pin[g]), .high_time(high_time[g]),
         .period(period[g]), .falls(falls[g]));
   end

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   function automatic logic [16:0] exp_len(input int c);
      return 17'h100 << c;
   endfunction
   function automatic logic [16:0] exp_high(input int c, logic [16:0] x);
      return (c == 0) ? 17'h100 - x : exp_len(c) - x;
   endfunction

   task automatic go(input logic [7:0] a, logic [7:0] w, logic s_wr, s_rd);
      @(posedge clock);
      bus_req <= '{addr: a, wdata: w, wr: s_wr, rd: s_rd};
   endtask
   task automatic write_reg(input logic [7:0] a, input logic [7:0] w);
      go(a, w, 1'b1, 1'b0);
   endtask
   task automatic read_reg(input logic [7:0] a, output logic [7:0] x);
      go(a, 8'h00, 1'b0, 1'b1);
      go(8'h00, 8'h00, 1'b0, 1'b0);
      #1;
      x = bus_rdata;
   endtask
   task automatic chk(input string what, logic [16:0] exp, logic [16:0] got);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d, mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic wait_falls(input int k, input int bound);
      logic [7:0] f0;
      int i;
      go(8'h00, 8'h00, 1'b0, 1'b0);
      f0 = falls[0];
      i = 0;
      while (falls[0] !== 8'(f0 + k) && i < bound) begin
         @(posedge clock);
         i++;
      end
      if (i >= bound) begin
         errors++;
         $display("unexpected timeout waiting for pin edges");
         end_of_test();
      end
   endtask

   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   initial begin
      reset = 1'b1;
      bus_req = '0;
      seed = 32'he3e4;
      errors = 0;
      checks_done = 0;
      repeat (6) @(posedge clock);
      reset <= 1'b0;
      foreach (RST_ADDRS[i]) begin
         read_reg(RST_ADDRS[i], d);
         chk("reset value", 17'h0, 17'(d));
      end
      $display("test reset values done");
      write_reg(8'h01, 8'h04);
      write_reg(8'h00, 8'h40);
      // 8-bit corner at the shortest pulse, longer lengths random
      for (int c = 0; c < 4; c++) begin
         seed = xs(seed);
         v = (c == 0) ? 17'h0ff : 17'(seed) & (exp_len(c) - 17'h1);
         if (v == 17'h0) v = 17'h1;
         write_reg(8'h00, 8'h40);
         write_reg(8'h02, (c == 0) ? 8'h00 : 8'(8'h80 | c));
         for (int m = 0; m < 2; m++) begin
            write_reg(8'(8'h11 + 4 * m), v[7:0]);
            write_reg(8'(8'h12 + 4 * m), (c == 0) ? v[7:0] : v[15:8]);
         end
         write_reg(8'h02, 8'(c));
         // Module 1 first, so every counted fall of pin 0 is shared
         write_reg(8'h14, 8'h42);
         write_reg(8'h10, 8'h4a);
         wait_falls(2, 3 * exp_len(c));
         for (int m = 0; m < 2; m++) begin
            chk("pwm high time", exp_high(c, v), high_time[m]);
            chk("pwm period", exp_len(c), period[m]);
         end
         read_reg(8'h02, d);
         chk("cycle overflow", 17'(8'h20 | c), 17'(d & 8'h23));
         read_reg(8'h00, d);
         chk("match flags", 17'h1, 17'(d & 8'h03));
      end
      $display("test pwm lengths done");
      write_reg(8'h10, 8'h4b);
      wait_falls(2, 4200);
      chk("irq with enabled flag", 17'h1, 17'(irq));
      write_reg(8'h00, 8'h40);
      write_reg(8'h10, 8'h42);
      wait_falls(1, 2100);
      chk("irq with flag disabled", 17'h0, 17'(irq));
      $display("test irq done");
      for (int k = 0; k < 2; k++) begin
         seed = xs(seed);
         o = (k == 0) ? 8'h00 : seed[7:0] | 8'h01;
         e = (o == 8'h00) ? 17'h100 : 17'(o);
         write_reg(8'h10, 8'h46);
         write_reg(8'h11, seed[15:8]);
         write_reg(8'h12, o);
         wait_falls(2, 1100);
         chk("toggle spacing", e, high_time[0]);
         chk("square period", 17'(2 * e), period[0]);
      end
      $display("test frequency output done");
      write_reg(8'h10, 8'h42);
      write_reg(8'h11, 8'h10);
      read_reg(8'h10, d);
      chk("mode after low write", 17'h02, 17'(d));
      hits = 0;
      for (int i = 0; i < 600; i++) begin
         @(posedge clock);
         if (module_output_pin[0] !== 1'b0) hits++;
      end
      chk("disabled pwm high cycles", 17'h0, 17'(hits));
      write_reg(8'h12, 8'h10);
      read_reg(8'h10, d);
      chk("mode after high write", 17'h42, 17'(d));
      $display("test comparator enable done");
      write_reg(8'h03, 8'h00);
      write_reg(8'h04, 8'hff);
      // Match interrupts on, so duty writes can follow the match
      write_reg(8'h10, 8'hcb);
      write_reg(8'h11, 8'h80);
      write_reg(8'h12, 8'hff);
      write_reg(8'h00, 8'h40);
      wait_falls(1, 400);
      chk("wide pwm high time", 17'h80, high_time[0]);
      read_reg(8'h00, d);
      chk("counter overflow", 17'h80, 17'(d & 8'h80));
      write_reg(8'h00, 8'h40);
      write_reg(8'h04, 8'hff);
      hits = 0;
      do begin
         @(posedge clock);
         hits++;
      end while (irq !== 1'b1 && hits < 400);
      if (hits >= 400) begin
         errors++;
         $display("unexpected timeout waiting for match irq");
         end_of_test();
      end
      write_reg(8'h11, 8'hc0);
      write_reg(8'h12, 8'hff);
      // Spacer keeps the disable fall out of the count below
      read_reg(8'h00, d);
      chk("wide match flag", 17'h1, 17'(d & 8'h01));
      wait_falls(1, 400);
      chk("synced wide high time", 17'h40, high_time[0]);
      $display("test wide pwm done");
      end_of_test();
   end
endmodule
